// File: hw/uart_host_regs.sv
/*
 * uart_host_regs: APB register set, baud generator, transmit and receive
 * queues and serial framing of one serial port.
 * Assumes APB signals, rxd_i and modem inputs are synchronous to mclk_i.
 */
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module uart_host_regs
    import uart_regs_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE_ADDR = 12'h000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire modem_in_s modem_i,
    output modem_out_s modem_o,
    output logic irq_o
);

    state_s st_reg;
    state_s st_next;
    logic [3:0] iid;

    // highest pending source; gated enables make all-clear read as none
    function automatic logic [3:0] int_id(input state_s st);
        logic ls;
        logic rda;
        logic tmo;
        logic thr;
        logic ms;
        ls = st.ien[IEN_LS] & (st.oe | st.pe | st.fe | st.bi);
        rda = st.ien[IEN_RDA] & (st.qen ? (st.rn >= TRIG_LVL[st.trig]) : (st.rn != 5'h00));
        tmo = st.ien[IEN_RDA] & st.qen & (st.rn != 5'h00) & (st.tocnt == TIMEOUT_CNT);
        thr = st.ien[IEN_THR] & st.thre_p;
        ms = st.ien[IEN_MS] & (|st.msr_d);
        int_id = IIR_NONE;
        if (ls) begin
            int_id = IIR_LS;
        end else if (rda) begin
            int_id = IIR_RDA;
        end else if (tmo) begin
            int_id = IIR_TMO;
        end else if (thr) begin
            int_id = IIR_THR;
        end else if (ms) begin
            int_id = IIR_MS;
        end
    endfunction : int_id

    assign iid = int_id(st_reg);

    // whole next state of the port
    always_comb begin
        logic tick;
        logic hit;
        logic wr;
        logic rd;
        logic dla;
        logic push_tx;
        logic pop_tx;
        logic push_rx;
        logic pop_rx;
        logic flush_tx;
        logic flush_rx;
        logic [2:0] idx;
        logic [2:0] wl;
        logic [4:0] lim;
        logic [5:0] stop_len;
        logic [7:0] wb;
        logic [7:0] rdv;
        logic [7:0] rdat;
        logic [10:0] rent;
        logic [3:0] mcur;
        st_next = st_reg;
        tick = (st_reg.bcnt == 16'h0000);
        hit = (apb_i.paddr[ADDR_W-1:5] == BASE_ADDR[ADDR_W-1:5]) && (apb_i.paddr[1:0] == 2'h0);
        idx = apb_i.paddr[4:2];
        wr = apb_i.psel & apb_i.penable & hit & apb_i.pwrite;
        rd = apb_i.psel & apb_i.penable & hit & ~apb_i.pwrite;
        dla = st_reg.fmt[FMT_DLA];
        push_tx = 1'b0;
        pop_tx = 1'b0;
        push_rx = 1'b0;
        pop_rx = 1'b0;
        flush_tx = 1'b0;
        flush_rx = 1'b0;
        wl = {1'b1, st_reg.fmt[1:0]}; // bits per character minus one
        lim = st_reg.qen ? 5'(QDEPTH) : 5'h01;
        wb = apb_i.pwdata[7:0];
        rdv = 8'h00;
        rdat = st_reg.rsh >> (3'h7 - wl);
        rent = '0;
        mcur = modem_i;
        if (!st_reg.fmt[FMT_STOP]) begin
            stop_len = STOP_1;
        end else if (st_reg.fmt[1:0] == 2'h0) begin
            stop_len = STOP_15;
        end else begin
            stop_len = STOP_2;
        end

        // divisor 1 ticks every clock; a count left above a new divisor reloads at once, so 0 halts
        st_next.bcnt = (tick || st_reg.bcnt >= st_reg.div) ? st_reg.div - 16'h0001 : st_reg.bcnt - 16'h0001;

        // read mux
        if (idx == IDX_DATA) begin
            rdv = dla ? st_reg.div[7:0] : st_reg.rxq[st_reg.rr][7:0];
        end else if (idx == IDX_IEN) begin
            rdv = dla ? st_reg.div[15:8] : {4'h0, st_reg.ien};
        end else if (idx == IDX_ID) begin
            rdv = {st_reg.qen, st_reg.qen, 2'h0, iid};
        end else if (idx == IDX_FMT) begin
            rdv = st_reg.fmt;
        end else if (idx == IDX_HSO) begin
            rdv = {3'h0, st_reg.hso};
        end else if (idx == IDX_LINE) begin
            rdv = {st_reg.qen & (st_reg.pe | st_reg.fe | st_reg.bi),
                   (st_reg.tn == 5'h00) && (st_reg.tst == TX_IDLE), st_reg.tn == 5'h00,
                   st_reg.bi, st_reg.fe, st_reg.pe, st_reg.oe, st_reg.rn != 5'h00};
        end else if (idx == IDX_HSI) begin
            rdv = {mcur, st_reg.msr_d};
        end else begin
            rdv = st_reg.scr;
        end

        // caught in setup so the access phase answers from a flop at once
        if (apb_i.psel & ~apb_i.penable) begin
            st_next.prdata = hit ? rdv : 8'h00;
            st_next.perr = ~hit;
        end

        // register writes in the access phase
        if (wr) begin
            if (idx == IDX_DATA) begin
                if (dla) begin
                    st_next.div[7:0] = wb;
                end else begin
                    push_tx = st_reg.tn < lim; // full queue drops the byte
                    st_next.thre_p = 1'b0;
                end
            end else if (idx == IDX_IEN) begin
                if (dla) begin
                    st_next.div[15:8] = wb;
                end else begin
                    st_next.ien = wb[3:0];
                end
            end else if (idx == IDX_ID) begin
                if (wb[QC_EN]) begin
                    st_next.qen = 1'b1;
                    st_next.trig = wb[7:6];
                    flush_rx = wb[QC_RXCLR] | ~st_reg.qen;
                    flush_tx = wb[QC_TXCLR] | ~st_reg.qen;
                end else begin
                    st_next.qen = 1'b0;
                    flush_rx = st_reg.qen;
                    flush_tx = st_reg.qen;
                end
                // bits 3 to 5 are dropped: no transfer-request pins
            end else if (idx == IDX_FMT) begin
                st_next.fmt = wb;
            end else if (idx == IDX_HSO) begin
                st_next.hso = wb[4:0];
            end else if (idx == IDX_SCR) begin
                st_next.scr = wb;
            end
        end

        // read side effects; sets below come later, so a set wins a clear
        if (rd) begin
            if (idx == IDX_DATA && !dla) begin
                pop_rx = st_reg.rn != 5'h00;
            end else if (idx == IDX_ID && iid == IIR_THR) begin
                st_next.thre_p = 1'b0;
            end else if (idx == IDX_LINE) begin
                st_next.oe = 1'b0;
                st_next.pe = 1'b0;
                st_next.fe = 1'b0;
                st_next.bi = 1'b0;
            end else if (idx == IDX_HSI) begin
                st_next.msr_d = 4'h0;
            end
        end

        // transmitter
        if (tick) begin
            st_next.tt = st_reg.tt + 6'h01;
        end
        case (st_reg.tst)
            TX_IDLE: begin
                st_next.tt = 6'h00;
                if (tick && st_reg.tn != 5'h00) begin
                    pop_tx = 1'b1;
                    st_next.tsh = st_reg.txq[st_reg.tr];
                    st_next.tpar = 1'b0;
                    st_next.tst = TX_START;
                end
            end
            TX_START: begin
                if (tick && st_reg.tt[3:0] == BIT_END) begin
                    st_next.tt = 6'h00;
                    st_next.tb = 3'h0;
                    st_next.tst = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tick && st_reg.tt[3:0] == BIT_END) begin
                    st_next.tt = 6'h00;
                    st_next.tsh = st_reg.tsh >> 1;
                    st_next.tpar = st_reg.tpar ^ st_reg.tsh[0];
                    st_next.tb = st_reg.tb + 3'h1;
                    if (st_reg.tb == wl) begin
                        st_next.tst = st_reg.fmt[FMT_PEN] ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                if (tick && st_reg.tt[3:0] == BIT_END) begin
                    st_next.tt = 6'h00;
                    st_next.tst = TX_STOP;
                end
            end
            default: begin
                if (tick && st_reg.tt == stop_len) begin
                    st_next.tst = TX_IDLE;
                end
            end
        endcase
        if (pop_tx && st_reg.tn == 5'h01 && !push_tx) begin
            st_next.thre_p = 1'b1;
        end
        if (wr && idx == IDX_IEN && !dla && wb[IEN_THR] && !st_reg.ien[IEN_THR] && st_reg.tn == 5'h00) begin
            st_next.thre_p = 1'b1;
        end

        // line level follows the state the transmitter enters
        case (st_next.tst)
            TX_START: st_next.txd_low = 1'b1;
            TX_DATA: st_next.txd_low = ~st_next.tsh[0];
            TX_PAR: st_next.txd_low = st_next.fmt[FMT_STICK] ? st_next.fmt[FMT_EVEN] :
                                      ~(st_next.tpar ^ ~st_next.fmt[FMT_EVEN]);
            default: st_next.txd_low = 1'b0;
        endcase
        st_next.txd_low = st_next.txd_low | st_next.fmt[FMT_BRK];

        // receiver: sample each bit in its middle, 8 ticks after start edge
        if (tick) begin
            st_next.rt = st_reg.rt + 4'h1;
        end
        case (st_reg.rst)
            RX_IDLE: begin
                st_next.rt = 4'h0;
                if (!rxd_i) begin
                    st_next.rst = RX_START;
                end
            end
            RX_START: begin
                if (tick && st_reg.rt == SAMPLE_AT) begin
                    st_next.rt = 4'h0;
                    st_next.rb = 3'h0;
                    st_next.rpe = 1'b0;
                    // a high line here was a glitch, not a start bit
                    st_next.rst = rxd_i ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (tick && st_reg.rt == BIT_END) begin
                    st_next.rsh = {rxd_i, st_reg.rsh[7:1]};
                    st_next.rpe = st_reg.rpe ^ rxd_i;
                    st_next.rb = st_reg.rb + 3'h1;
                    if (st_reg.rb == wl) begin
                        st_next.rst = st_reg.fmt[FMT_PEN] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (tick && st_reg.rt == BIT_END) begin
                    // odd wants a total of one, even of zero, sticky a fixed bit
                    st_next.rpe = (st_reg.fmt[FMT_STICK] ? rxd_i : st_reg.rpe ^ rxd_i) == st_reg.fmt[FMT_EVEN];
                    st_next.rst = RX_STOP;
                end
            end
            default: begin
                // only the first stop bit is checked
                if (tick && st_reg.rt == BIT_END) begin
                    rent = {~rxd_i & (rdat == 8'h00), ~rxd_i, st_reg.fmt[FMT_PEN] & st_reg.rpe, rdat};
                    st_next.rst = RX_IDLE;
                    if (st_reg.rn >= lim) begin
                        st_next.oe = 1'b1;
                    end else begin
                        push_rx = 1'b1;
                    end
                    st_next.bi = st_next.bi | rent[10];
                    st_next.fe = st_next.fe | rent[9];
                    st_next.pe = st_next.pe | rent[8];
                end
            end
        endcase

        // transmit queue; a flush leaves the shift register alone
        if (push_tx) begin
            st_next.txq[st_reg.tw] = wb;
            st_next.tw = st_reg.tw + 4'h1;
        end
        if (pop_tx) begin
            st_next.tr = st_reg.tr + 4'h1;
        end
        st_next.tn = st_reg.tn + {4'h0, push_tx} - {4'h0, pop_tx};
        if (flush_tx) begin
            st_next.tw = 4'h0;
            st_next.tr = 4'h0;
            st_next.tn = 5'h00;
        end

        // receive queue
        if (push_rx) begin
            st_next.rxq[st_reg.rw] = rent;
            st_next.rw = st_reg.rw + 4'h1;
        end
        if (pop_rx) begin
            st_next.rr = st_reg.rr + 4'h1;
        end
        st_next.rn = st_reg.rn + {4'h0, push_rx} - {4'h0, pop_rx};
        if (flush_rx) begin
            st_next.rw = 4'h0;
            st_next.rr = 4'h0;
            st_next.rn = 5'h00;
        end

        // character timeout restarts on any queue movement
        if (push_rx || pop_rx || st_reg.rn == 5'h00) begin
            st_next.tocnt = 10'h000;
        end else if (tick && st_reg.tocnt != TIMEOUT_CNT) begin
            st_next.tocnt = st_reg.tocnt + 10'h001;
        end

        // handshake input change; ri reports only its falling edge
        st_next.mprev = mcur;
        st_next.msr_d = st_next.msr_d | {mcur[3] ^ st_reg.mprev[3], st_reg.mprev[2] & ~mcur[2],
                                         mcur[1] ^ st_reg.mprev[1], mcur[0] ^ st_reg.mprev[0]};
    end

    // single state register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs; pready is tied high since every access finishes in one cycle
    assign prdata_o = {24'h000000, st_reg.prdata};
    assign pready_o = 1'b1;
    assign pslverr_o = st_reg.perr;
    assign txd_o = ~st_reg.txd_low;
    assign modem_o = st_reg.hso[3:0];
    assign irq_o = st_reg.hso[HSO_IRQ_OUTPUT_GATE] & ~iid[0];
endmodule : uart_host_regs
`default_nettype wire

// File: hw/uart_regs_pkg.sv
/*
 * uart_regs_pkg: register indices, field positions, timing counts,
 * reset state and carrier types of one serial port register interface.
 * Assumes a 32-bit APB slave where each 8-bit register takes one word.
 */
package uart_regs_pkg;
    localparam int ADDR_W = 12;
    localparam int QDEPTH = 16;
    // register indices; byte address is base plus four times the index
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IEN = 3'h1;
    localparam logic [2:0] IDX_ID = 3'h2;
    localparam logic [2:0] IDX_FMT = 3'h3;
    localparam logic [2:0] IDX_HSO = 3'h4;
    localparam logic [2:0] IDX_LINE = 3'h5;
    localparam logic [2:0] IDX_HSI = 3'h6;
    localparam logic [2:0] IDX_SCR = 3'h7;
    // character_format fields
    localparam int FMT_DLA = 7;
    localparam int FMT_BRK = 6;
    localparam int FMT_STICK = 5;
    localparam int FMT_EVEN = 4;
    localparam int FMT_PEN = 3;
    localparam int FMT_STOP = 2;
    // interrupt_enables, queue_control and handshake_outputs fields
    localparam int IEN_RDA = 0;
    localparam int IEN_THR = 1;
    localparam int IEN_LS = 2;
    localparam int IEN_MS = 3;
    localparam int QC_EN = 0;
    localparam int QC_RXCLR = 1;
    localparam int QC_TXCLR = 2;
    localparam int HSO_IRQ_OUTPUT_GATE = 3;
    // receive trigger levels in bytes, indexed by queue_control bits 7:6
    localparam logic [3:0][4:0] TRIG_LVL = {5'h0e, 5'h08, 5'h04, 5'h01};
    // bit timing in sixteenths of a bit
    localparam logic [3:0] SAMPLE_AT = 4'h7;
    localparam logic [3:0] BIT_END = 4'hf;
    localparam logic [5:0] STOP_1 = 6'h0f;
    localparam logic [5:0] STOP_15 = 6'h17;
    localparam logic [5:0] STOP_2 = 6'h1f;
    // character timeout: four characters of eleven bits
    localparam int TO_CHARS = 4;
    localparam int TO_BITS = 11;
    localparam int TIMEOUT_TICKS = TO_CHARS * TO_BITS * 16;
    localparam logic [9:0] TIMEOUT_CNT = 10'(TIMEOUT_TICKS);
    // interrupt_source_id low nibble
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LS = 4'h6;
    localparam logic [3:0] IIR_RDA = 4'h4;
    localparam logic [3:0] IIR_TMO = 4'hc;
    localparam logic [3:0] IIR_THR = 4'h2;
    localparam logic [3:0] IIR_MS = 4'h0;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_st_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_st_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_in_s;

    typedef struct packed {
        logic irq_output_gate;
        logic out1;
        logic rts;
        logic dtr;
    } modem_out_s;

    typedef struct packed {
        logic [3:0] ien;
        logic [7:0] fmt;
        logic [4:0] hso;
        logic [7:0] scr;
        logic [15:0] div;
        logic qen;
        logic [1:0] trig;
        logic [15:0] bcnt;
        logic [15:0][7:0] txq;
        logic [3:0] tw;
        logic [3:0] tr;
        logic [4:0] tn;
        tx_st_e tst;
        logic [5:0] tt;
        logic [2:0] tb;
        logic [7:0] tsh;
        logic tpar;
        logic txd_low;
        logic [15:0][10:0] rxq;
        logic [3:0] rw;
        logic [3:0] rr;
        logic [4:0] rn;
        rx_st_e rst;
        logic [3:0] rt;
        logic [2:0] rb;
        logic [7:0] rsh;
        logic rpe;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic thre_p;
        logic [3:0] mprev;
        logic [3:0] msr_d;
        logic [9:0] tocnt;
        logic [7:0] prdata;
        logic perr;
    } state_s;

    // everything clears: interrupts off, queues off, line idle high
    localparam state_s STATE_RST = '0;
endpackage : uart_regs_pkg

// File: verification/serial_peer.sv
/*
 * serial_peer: remote 8N1 serial device on the line side.
 * Assumes a divisor of one, so a bit lasts sixteen clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    input wire logic mclk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    int bit_clks = 16;
    logic [7:0] got[$];
    logic [7:0] sh;
    // line rests high between frames, as the pull-up would hold it
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_i);
            rxd_o <= f[i];
            repeat (bit_clks - 1) @(posedge mclk_i);
        end
    endtask : send
    // capture frames mid-bit; the stop half-bit is waited out before rearming
    always begin
        @(negedge txd_i);
        repeat (bit_clks / 2) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge mclk_i);
            sh[i] = txd_i;
        end
        repeat (bit_clks) @(posedge mclk_i);
        got.push_back(sh);
    end
endmodule : serial_peer
`default_nettype wire

// File: verification/uart_host_register_interface_tb.sv
/*
 * uart_host_register_interface_tb: self-checking bench of the register block.
 * Assumes serial_peer on the line and the checker bound to the design.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_host_register_interface_tb;
    import uart_regs_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    apb_req_s apb_i = '0;
    modem_in_s modem_i = '0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, rxd_i, txd_o, irq_o, er;
    modem_out_s modem_o;
    int err_count = 0;
    int n_tests = 0;
    int seed = 19;
    logic [7:0] rd, v, x;
    always #2.5 mclk_i = ~mclk_i;
    uart_host_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o),
        .modem_i(modem_i), .modem_o(modem_o), .irq_o(irq_o));
    serial_peer peer (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask : chk
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // one transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
        @(posedge mclk_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_count++;
            test_done();
        end
        rd = prdata_o[7:0];
        er = pslverr_o;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : apb
    task automatic w(input logic [2:0] i, input logic [7:0] d);
        apb(1'b1, {7'h0, i, 2'b00}, d);
    endtask : w
    task automatic rc(input logic [2:0] i, input logic [7:0] e);
        apb(1'b0, {7'h0, i, 2'b00}, 8'h00);
        chk("register", rd, e);
    endtask : rc
    // irq is looked at mid-cycle, after the edge's updates have landed
    task automatic ci(input logic e);
        @(negedge mclk_i);
        chk("irq", irq_o, e);
    endtask : ci
    function automatic logic [7:0] idv(input logic q, input logic [3:0] c);
        return {q, q, 2'b00, c};
    endfunction : idv
    initial begin
        repeat (100000) @(posedge mclk_i);
        err_count++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        ci(1'b0);
        rc(IDX_IEN, 8'h00);
        rc(IDX_ID, idv(1'b0, IIR_NONE));
        apb(1'b0, 12'h020, 8'h00);
        chk("err", er, 1'b1);
        apb(1'b0, 12'h00d, 8'h00);
        chk("err", er, 1'b1);
        $display("test reset_map done");
        w(IDX_FMT, 8'h83);
        w(IDX_DATA, 8'h01);
        w(IDX_IEN, 8'ha5);
        rc(IDX_IEN, 8'ha5);
        w(IDX_IEN, 8'h00);
        rc(IDX_DATA, 8'h01);
        w(IDX_FMT, 8'h03);
        repeat (4) begin
            v = 8'($random(seed));
            w(IDX_IEN, v);
            rc(IDX_IEN, {4'h0, v[3:0]});
        end
        w(IDX_IEN, 8'h00);
        v = 8'($random(seed));
        x = 8'($random(seed));
        w(IDX_DATA, v);
        w(IDX_DATA, x);
        for (int n = 0; n < 2000 && peer.got.size() < 2; n++) @(posedge mclk_i);
        chk("tx count", peer.got.size(), 2);
        chk("tx first", peer.got[0], v);
        chk("tx second", peer.got[1], x);
        $display("test transmit done");
        w(IDX_IEN, 8'h01);
        v = 8'($random(seed));
        peer.send(v);
        ci(1'b0);
        w(IDX_HSO, 8'h08);
        ci(1'b1);
        chk("gate", modem_o, 4'h8);
        rc(IDX_ID, idv(1'b0, IIR_RDA));
        rc(IDX_DATA, v);
        ci(1'b0);
        w(IDX_IEN, 8'h02);
        ci(1'b1);
        rc(IDX_ID, idv(1'b0, IIR_THR));
        ci(1'b0);
        w(IDX_IEN, 8'h08);
        modem_i.cts <= 1'b1;
        repeat (4) @(posedge mclk_i);
        ci(1'b1);
        rc(IDX_ID, idv(1'b0, IIR_MS));
        rc(IDX_HSI, 8'h11);
        ci(1'b0);
        w(IDX_IEN, 8'h00);
        modem_i.cts <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ci(1'b0);
        rc(IDX_ID, idv(1'b0, IIR_NONE));
        // second byte with the holding register full must overrun and be lost
        w(IDX_IEN, 8'h05);
        v = 8'($random(seed));
        x = 8'($random(seed));
        peer.send(v);
        peer.send(x);
        ci(1'b1);
        rc(IDX_ID, idv(1'b0, IIR_LS));
        rc(IDX_LINE, 8'h63);
        rc(IDX_ID, idv(1'b0, IIR_RDA));
        rc(IDX_DATA, v);
        w(IDX_IEN, 8'h00);
        $display("test interrupts done");
        w(IDX_IEN, 8'h01);
        for (int t = 0; t < 4; t++) begin
            w(IDX_ID, {t[1:0], 6'h0b});
            ci(1'b0);
            rc(IDX_ID, idv(1'b1, IIR_NONE));
            for (int k = 1; k < TRIG_LVL[t]; k++) peer.send(8'($random(seed)));
            ci(1'b0);
            peer.send(8'($random(seed)));
            ci(1'b1);
        end
        w(IDX_ID, 8'h00);
        ci(1'b0);
        rc(IDX_ID, idv(1'b0, IIR_NONE));
        $display("test queues done");
        test_done();
    end
endmodule : uart_host_register_interface_tb
`default_nettype wire

// File: verification/uart_host_regs_sva.sv
/*
 * uart_host_regs_sva: port-level checks of the serial port register block.
 * Assumes one clock domain and a register set at the BASE_ADDR words.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_host_regs_sva
    import uart_regs_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE_ADDR = 12'h000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire apb_req_s apb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire modem_in_s modem_i,
    input wire modem_out_s modem_o,
    input wire logic irq_o
);
    wire logic acc = apb_i.psel && apb_i.penable;
    wire logic hit = apb_i.paddr[11:5] == BASE_ADDR[11:5] && apb_i.paddr[1:0] == 2'b00;
    wire logic [2:0] idx = apb_i.paddr[4:2];
    logic dla_reg;
    // shadow of the latch access bit, so ien reads can be told from divisor reads
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dla_reg <= 1'b0;
        end else if (acc && hit && apb_i.pwrite && idx == IDX_FMT) begin
            dla_reg <= apb_i.pwdata[FMT_DLA];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr_hso;
        acc && hit && apb_i.pwrite && idx == IDX_HSO;
    endsequence
    sequence s_rd_at(logic [2:0] i);
        acc && hit && !apb_i.pwrite && idx == i;
    endsequence
    a_gate_blocks: assert property (!modem_o.irq_output_gate |-> !irq_o) else $error("irq without gate");
    a_gate_write: assert property (s_wr_hso |=> modem_o.irq_output_gate == $past(apb_i.pwdata[HSO_IRQ_OUTPUT_GATE]))
        else $error("gate bit not stored");
    a_bad_addr: assert property (acc && !hit |-> pslverr_o) else $error("unmapped not refused");
    a_good_addr: assert property (acc && hit |-> !pslverr_o) else $error("mapped refused");
    a_ien_upper: assert property (s_rd_at(IDX_IEN) and !dla_reg |-> prdata_o[7:4] == 4'h0)
        else $error("ien upper bits set");
    a_id_mode: assert property (s_rd_at(IDX_ID) |-> prdata_o[7] == prdata_o[6] && prdata_o[5:4] == 2'b00)
        else $error("id mode bits wrong");
    a_word_width: assert property (acc |-> prdata_o[31:8] == 24'h0) else $error("read above bit 7");
    a_low_min: assert property ($fell(txd_o) |-> !txd_o [*8]) else $error("serial bit too short");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && txd_o && modem_o == '0)
        else $error("not quiet after reset");
endmodule : uart_host_regs_sva
bind uart_host_regs uart_host_regs_sva #(.BASE_ADDR(BASE_ADDR)) u_sva (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o), .modem_i(modem_i),
    .modem_o(modem_o), .irq_o(irq_o));
`default_nettype wire
